// file: inc/sbsc_defines.svh
`ifndef SBSC_DEFINES_SVH
`define SBSC_DEFINES_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define SBSC_ADDR_STATE_CODE 8'h00
`define SBSC_ADDR_CONTROL 8'h04
`define SBSC_ADDR_EVENT 8'h08

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define SBSC_CODE_RESET 8'hF8
`define SBSC_CODE_LOW_W 3
`define SBSC_LOW_ZERO 3'h0
`define SBSC_CTRL_FLAG_BIT 0
`define SBSC_STATE_COUNT 28
`define SBSC_RESP_OKAY 2'h0
`define SBSC_RESP_SLVERR 2'h2

`endif

// file: inc/sbsc_pkg.sv
package sbsc_pkg;
	typedef logic [4:0] sbsc_state_t;
	typedef enum {SBSC_IDLE, SBSC_RESP} sbsc_axi_e;
endpackage : sbsc_pkg

// file: hdl/sbsc_code_reg.sv
`timescale 1ns/1ps
`include "sbsc_defines.svh"

module sbsc_code_reg (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Event from the interface state machine
	input wire logic state_event,
	input wire sbsc_pkg::sbsc_state_t state_index,
	// Flag clear from software
	input wire logic flag_clear,
	// Outputs
	output logic [7:0] serial_bus_state_code,
	output logic serial_interrupt_flag
);
	// ----------------------------------------
	// Code and flag load together
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			serial_bus_state_code <= `SBSC_CODE_RESET;
			serial_interrupt_flag <= 1'b0;
		end else if (state_event) begin
			// Upper bits carry the state, low bits forced zero
			serial_bus_state_code <= {state_index, `SBSC_LOW_ZERO}; // R3 R4 R7
			serial_interrupt_flag <= 1'b1; // R7
		end else if (flag_clear) begin
			serial_interrupt_flag <= 1'b0;
		end
	end

	a_low_bits_zero: assert property (@(posedge ref_clk) disable iff (rst)
		serial_interrupt_flag |-> serial_bus_state_code[2:0] == 3'h0) // R4
		else $error("low code bits not zero while flag set");
	a_code_with_flag: assert property (@(posedge ref_clk) disable iff (rst)
		state_event |=> serial_interrupt_flag && serial_bus_state_code[7:3] == $past(state_index)) // R7
		else $error("code and flag not loaded together");
endmodule : sbsc_code_reg

// file: hdl/sbsc_status_top.sv
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "sbsc_defines.svh"
// Overview of operation
// [R1] An 8-bit register holds the code of the present interface state.
// [R2] Twenty-eight states, each with its own distinct code.
// [R3] Only the upper five bits vary between states.
// [R4] Low three bits read zero while the interrupt flag is set.
// [R5] Software trusts the code only while the flag reads one.
// [R6] Software never writes the code register; writes are refused here.
// [R7] Code loads in the same edge the interrupt flag rises.

module sbsc_status_top (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// State machine side
	input wire logic state_event,
	input wire sbsc_pkg::sbsc_state_t state_index,
	output logic serial_interrupt_flag,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (`SBSC_STATE_COUNT > 32) begin : g_chk
		$error("state count exceeds five-bit code space");
	end

	logic [7:0] code;
	logic [7:0] aw_addr;
	logic aw_held;
	logic w_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [7:0] event_count;

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire aw_have = aw_held || aw_take;
	wire w_have = w_held || w_take;
	wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
	wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
	wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
	wire wr_fire = aw_have && w_have && !s_axi_bvalid;
	wire wr_ctrl = wr_addr == `SBSC_ADDR_CONTROL;
	// Code register is read-only to software; a write gets SLVERR
	wire wr_ok = wr_ctrl; // R6
	wire flag_clear = wr_fire && wr_ctrl && wr_strb[0] &&
		!wr_data[`SBSC_CTRL_FLAG_BIT];

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SBSC_RESP_OKAY;
		end else begin
			if (aw_take && !wr_fire) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (w_take && !wr_fire) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `SBSC_RESP_OKAY : `SBSC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire rd_code = s_axi_araddr == `SBSC_ADDR_STATE_CODE;
	wire rd_ctrl = s_axi_araddr == `SBSC_ADDR_CONTROL;
	wire rd_evt = s_axi_araddr == `SBSC_ADDR_EVENT;
	wire [31:0] rd_value = rd_code ? {24'h000000, code} :
		rd_ctrl ? {31'h0000_0000, serial_interrupt_flag} :
		rd_evt ? {24'h000000, event_count} : 32'h0000_0000;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SBSC_RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_value; // R1 R5
			s_axi_rresp <= (rd_code || rd_ctrl || rd_evt) ? `SBSC_RESP_OKAY :
				`SBSC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Diagnostic count of state entries
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			event_count <= 8'h00;
		end else if (state_event) begin
			event_count <= event_count + 8'h01;
		end
	end

	// ----------------------------------------
	// Code register
	// ----------------------------------------
	sbsc_code_reg u_code (
		.ref_clk(ref_clk),
		.rst(rst),
		.state_event(state_event),
		.state_index(state_index), // R2
		.flag_clear(flag_clear),
		.serial_bus_state_code(code),
		.serial_interrupt_flag(serial_interrupt_flag)
	);

	sequence s_code_write;
		wr_fire && !wr_ctrl;
	endsequence
	// A state entry in the same cycle may legally move the code
	a_code_write_refused: assert property (@(posedge ref_clk) disable iff (rst)
		s_code_write && !state_event |=> s_axi_bvalid && s_axi_bresp == `SBSC_RESP_SLVERR &&
		$stable(code)) // R6
		else $error("code write not refused");
	a_read_code: assert property (@(posedge ref_clk) disable iff (rst)
		ar_take && rd_code && !state_event |=> s_axi_rvalid && s_axi_rdata[7:0] == code) // R1
		else $error("code read mismatch");
	a_set_over_clear: assert property (@(posedge ref_clk) disable iff (rst)
		state_event && flag_clear |=> serial_interrupt_flag) // R7
		else $error("flag clear beat set");
	a_clear_flag: assert property (@(posedge ref_clk) disable iff (rst)
		flag_clear && !state_event |=> !serial_interrupt_flag) // R5
		else $error("flag not cleared");
	a_reset_code: assert property (@(posedge ref_clk)
		rst |=> code == `SBSC_CODE_RESET && !serial_interrupt_flag) // R1
		else $error("bad reset code");
	a_upper_bits: assert property (@(posedge ref_clk) disable iff (rst)
		state_event ##1 !state_event |-> code[7:3] == $past(state_index, 1)) // R3
		else $error("upper bits not the state");

	// ----------------------------------------
	// Bus handshake checks
	// ----------------------------------------
	// No new write halves while a response waits
	a_write_refused: assert property (@(posedge ref_clk) disable iff (rst)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) // R6
		else $error("write taken while response pending");
	a_write_answer: assert property (@(posedge ref_clk) disable iff (rst)
		wr_fire |=> s_axi_bvalid) // R6
		else $error("write not answered");
	a_ctrl_write_ok: assert property (@(posedge ref_clk) disable iff (rst)
		wr_fire && wr_ctrl |=> s_axi_bresp == `SBSC_RESP_OKAY) // R6
		else $error("control write refused");
	a_b_stands: assert property (@(posedge ref_clk) disable iff (rst)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) // R6
		else $error("write response dropped early");

	// ----------------------------------------
	// Read answer checks
	// ----------------------------------------
	a_read_answer: assert property (@(posedge ref_clk) disable iff (rst)
		ar_take |=> s_axi_rvalid) // R1
		else $error("read not answered");
	a_r_stands: assert property (@(posedge ref_clk) disable iff (rst)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) // R1
		else $error("read data dropped early");
	// Unmapped offsets read as zero with an error
	a_unmapped_read: assert property (@(posedge ref_clk) disable iff (rst)
		ar_take && !(rd_code || rd_ctrl || rd_evt) |=>
		s_axi_rresp == `SBSC_RESP_SLVERR && s_axi_rdata == 32'h0000_0000) // R1
		else $error("unmapped read not refused");
	a_read_flag: assert property (@(posedge ref_clk) disable iff (rst)
		ar_take && rd_ctrl && !state_event && !flag_clear |=>
		s_axi_rdata[0] == serial_interrupt_flag) // R7
		else $error("flag read mismatch");

	// ----------------------------------------
	// Event count check
	// ----------------------------------------
	// Count wraps silently; it is a diagnostic only
	a_count_step: assert property (@(posedge ref_clk) disable iff (rst)
		state_event |=> event_count == $past(event_count) + 8'h01) // R2
		else $error("event count did not step");
endmodule : sbsc_status_top

// file: tb/sbsc_sm_model.sv
`timescale 1ns/1ps

module sbsc_sm_model (
	// Clock
	input wire logic ref_clk,
	// Request from the bench
	input wire logic fire,
	input wire logic [4:0] pick,
	// Toward the block
	output logic state_event,
	output sbsc_pkg::sbsc_state_t state_index
);
	// Index toggles outside events so a stale value never looks valid
	initial state_index = 5'h00;
	always @(posedge ref_clk) begin
		state_event <= fire;
		state_index <= fire ? pick : ~state_index;
	end
endmodule : sbsc_sm_model

// file: tb/tb_smbus_status_code_register.sv
`timescale 1ns/1ps

module tb_smbus_status_code_register;
	logic ref_clk = 0, rst = 1, fire = 0, ev, flag;
	logic [4:0] pick = 5'h00;
	sbsc_pkg::sbsc_state_t idx;
	logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, awr, wr, bv, arr, rv;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rd, d, lfsr = 32'h6CDA;
	logic [1:0] br, rr, r;
	int bad_count = 0, checked = 0, exp_cnt = 0, k = 0;
	always #10 ref_clk = ~ref_clk;
	sbsc_sm_model far (.ref_clk(ref_clk), .fire(fire), .pick(pick), .state_event(ev),
		.state_index(idx));
	sbsc_status_top DUT (.ref_clk(ref_clk), .rst(rst), .state_event(ev), .state_index(idx),
		.serial_interrupt_flag(flag), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre));
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nxt
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		awa <= a;
		wd <= v;
		awv <= 1;
		wv <= 1;
		bre <= 1;
		forever begin
			@(posedge ref_clk);
			if (awr) awv <= 0;
			if (wr) wv <= 0;
			if (bv) break;
		end
		r = br;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a);
		ara <= a;
		arv <= 1;
		rre <= 1;
		forever begin
			@(posedge ref_clk);
			if (arr) arv <= 0;
			if (rv) break;
		end
		d = rd;
		r = rr;
	endtask : rd_reg
	task automatic end_of_test();
		if (bad_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 0;
		@(posedge ref_clk);
		rd_reg(8'h00);
		chk(d, 32'hF8);
		// First pass walks every state, second picks them at random
		for (int i = 0; i < 56; i++) begin
			lfsr = nxt(lfsr);
			k = (i < 28) ? i : lfsr % 28;
			pick <= k[4:0];
			fire <= 1;
			@(posedge ref_clk);
			fire <= 0;
			repeat (2) @(posedge ref_clk);
			exp_cnt++;
			chk(flag, 1);
			rd_reg(8'h00);
			chk(d, k * 8);
			rd_reg(8'h04);
			chk(d, 1);
			rd_reg(8'h08);
			chk(d, exp_cnt % 256);
			wr_reg(8'h04, 32'h0);
			chk(r, 0);
			chk(flag, 0);
			rd_reg(8'h04);
			chk(d, 0);
			wr_reg(8'h00, lfsr);
			chk(r, 2);
			rd_reg(8'h00);
			chk(d, k * 8);
		end
		rd_reg(8'h0C);
		chk({d[29:0], r}, 2);
		end_of_test();
	end
	initial begin
		repeat (6000) @(posedge ref_clk);
		bad_count++;
		end_of_test();
	end
endmodule : tb_smbus_status_code_register
